// File: logic/comparator_pkg.sv
package comparator_pkg;

	// Register offsets
	localparam logic [7:0] CTRL_A_OFFSET   = 8'h00;
	localparam logic [7:0] MUX_CTRL_OFFSET = 8'h02;
	localparam logic [7:0] INT_CTRL_OFFSET = 8'h06;
	localparam logic [7:0] STATUS_OFFSET   = 8'h07;

	// Reset values
	localparam logic [7:0] CTRL_A_RESET   = 8'h00;
	localparam logic [7:0] MUX_CTRL_RESET = 8'h00;
	localparam logic [7:0] INT_CTRL_RESET = 8'h00;

	// Control A fields
	localparam int unsigned RUN_STANDBY_BIT = 7;
	localparam int unsigned PIN_OUT_EN_BIT  = 6;
	localparam int unsigned EDGE_SEL_LSB    = 4;
	localparam int unsigned HYST_SEL_LSB    = 1;
	localparam int unsigned ENABLE_BIT      = 0;

	// Mux control fields
	localparam int unsigned INVERT_BIT  = 7;
	localparam int unsigned POS_SEL_BIT = 3;
	localparam int unsigned NEG_SEL_LSB = 0;

	// Interrupt control and status fields
	localparam int unsigned INT_ENABLE_BIT = 0;
	localparam int unsigned STATE_BIT      = 4;
	localparam int unsigned FLAG_BIT       = 0;

	// Edge selection codes
	localparam logic [1:0] EDGE_BOTH    = 2'h0;
	localparam logic [1:0] EDGE_FALLING = 2'h2;
	localparam logic [1:0] EDGE_RISING  = 2'h3;

	// Negative input code that needs the internal reference
	localparam logic [1:0] NEG_SEL_REFERENCE = 2'h2;

	// Sleep mode codes
	localparam logic [1:0] SLEEP_NONE      = 2'h0;
	localparam logic [1:0] SLEEP_IDLE      = 2'h1;
	localparam logic [1:0] SLEEP_STANDBY   = 2'h2;
	localparam logic [1:0] SLEEP_POWERDOWN = 2'h3;

	// Start-up timing
	localparam int unsigned CLK_PERIOD_NS      = 8;
	localparam int unsigned STARTUP_NS         = 2500;
	localparam int unsigned REF_STARTUP_NS     = 60000;
	localparam int unsigned STARTUP_CYCLES     = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned REF_STARTUP_CYCLES = (REF_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STARTUP_CNT_W      = 13;

	typedef enum logic [1:0] {
		ST_OFF      = 2'b00,
		ST_STARTING = 2'b01,
		ST_READY    = 2'b11
	} startup_state_t;

endpackage

// File: logic/comparator_control_logic.sv
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ns
module comparator_control_logic #(
	parameter int unsigned REF_STARTUP_CYCLES = comparator_pkg::REF_STARTUP_CYCLES
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_strobe,
	input  wire logic       rd_strobe,
	output logic      [7:0] rdata,
	input  wire logic       compare_raw,
	input  wire logic [1:0] sleep_mode,
	input  wire logic       others_need_clock,
	output logic            analog_enable,
	output logic            pos_input_select,
	output logic      [1:0] negative_input_select,
	output logic      [1:0] hysteresis_select,
	output logic            reference_request,
	output logic            event_out,
	output logic            pin_out,
	output logic            pin_oe_n,
	output logic            compare_ready,
	output logic            irq
);

	// Register group
	logic [7:0] ctrl_a_reg,   ctrl_a_next;
	logic [7:0] mux_ctrl_reg, mux_ctrl_next;
	logic       int_en_reg,   int_en_next;
	logic [7:0] rdata_reg,    rdata_next;
	logic       enable_reg,   enable_next;
	logic       pin_oe_n_reg, pin_oe_n_next;

	// Start-up group
	comparator_pkg::startup_state_t state_reg, state_next;
	logic [comparator_pkg::STARTUP_CNT_W-1:0] count_reg, count_next;
	logic                                     ready_reg, ready_next;
	logic                                     ref_req_reg, ref_req_next;

	// Synchroniser and flag group
	logic sync1_reg, sync2_reg, sync3_reg;
	logic flag_reg,  flag_next;
	logic irq_reg,   irq_next;

	logic       seen;
	logic       rise;
	logic       fall;
	logic       edge_hit;
	logic       set_flag;
	logic       clear_flag;
	logic       update_ok;
	logic       active;
	logic [1:0] edge_sel;

	assign edge_sel = ctrl_a_reg[comparator_pkg::EDGE_SEL_LSB +: 2];

	// The analog core decides the comparison; its raw result arrives here
	// asynchronously and is only inverted and gated on its way to the event output.
	assign seen = enable_reg & (compare_raw ^ mux_ctrl_reg[comparator_pkg::INVERT_BIT]);

	// Events leave with no synchroniser so routing keeps the comparator delay.
	assign event_out = seen;
	assign pin_out   = seen & ~pin_oe_n_reg;

	// Debug has no port here: nothing in the block reacts to it.
	always_comb begin
		active = ctrl_a_reg[comparator_pkg::ENABLE_BIT];
		unique case (sleep_mode)
			comparator_pkg::SLEEP_NONE:      active = ctrl_a_reg[comparator_pkg::ENABLE_BIT];
			comparator_pkg::SLEEP_IDLE:      active = ctrl_a_reg[comparator_pkg::ENABLE_BIT];
			comparator_pkg::SLEEP_STANDBY:   active = ctrl_a_reg[comparator_pkg::ENABLE_BIT]
				& ctrl_a_reg[comparator_pkg::RUN_STANDBY_BIT];
			comparator_pkg::SLEEP_POWERDOWN: active = 1'b0;
		endcase
	end

	// In standby the peripheral clock only runs if someone else asks for it;
	// without it the status flag cannot set and the interrupt request is held low.
	assign update_ok = ~((sleep_mode == comparator_pkg::SLEEP_STANDBY) & ~others_need_clock);

	always_comb begin
		ctrl_a_next   = ctrl_a_reg;
		mux_ctrl_next = mux_ctrl_reg;
		int_en_next   = int_en_reg;
		rdata_next    = 8'h00;
		if (wr_strobe) begin
			unique case (addr)
				comparator_pkg::CTRL_A_OFFSET:   ctrl_a_next   = wdata & 8'hF7;
				comparator_pkg::MUX_CTRL_OFFSET: mux_ctrl_next = wdata & 8'h8B;
				comparator_pkg::INT_CTRL_OFFSET: int_en_next   = wdata[comparator_pkg::INT_ENABLE_BIT];
				default: ;
			endcase
		end
		if (rd_strobe) begin
			unique case (addr)
				comparator_pkg::CTRL_A_OFFSET:   rdata_next = ctrl_a_reg;
				comparator_pkg::MUX_CTRL_OFFSET: rdata_next = mux_ctrl_reg;
				comparator_pkg::INT_CTRL_OFFSET: rdata_next = {7'h00, int_en_reg};
				comparator_pkg::STATUS_OFFSET: begin
					rdata_next[comparator_pkg::STATE_BIT] = sync3_reg;
					rdata_next[comparator_pkg::FLAG_BIT]  = flag_reg;
				end
				default: rdata_next = 8'h00;
			endcase
		end
		enable_next   = active;
		pin_oe_n_next = ~(active & ctrl_a_reg[comparator_pkg::PIN_OUT_EN_BIT]);
		// Registered so the reference sees one clean request level
		ref_req_next  = active
			& (mux_ctrl_next[comparator_pkg::NEG_SEL_LSB +: 2] == comparator_pkg::NEG_SEL_REFERENCE);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_a_reg   <= comparator_pkg::CTRL_A_RESET;
			mux_ctrl_reg <= comparator_pkg::MUX_CTRL_RESET;
			int_en_reg   <= 1'b0;
			rdata_reg    <= 8'h00;
			enable_reg   <= 1'b0;
			pin_oe_n_reg <= 1'b1;
			ref_req_reg  <= 1'b0;
		end else begin
			ctrl_a_reg   <= ctrl_a_next;
			mux_ctrl_reg <= mux_ctrl_next;
			int_en_reg   <= int_en_next;
			rdata_reg    <= rdata_next;
			enable_reg   <= enable_next;
			pin_oe_n_reg <= pin_oe_n_next;
			ref_req_reg  <= ref_req_next;
		end
	end

	// The reference has the longer wake-up, so its count takes over when it is selected.
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		unique case (state_reg)
			comparator_pkg::ST_OFF: begin
				if (enable_reg) begin
					state_next = comparator_pkg::ST_STARTING;
					if (mux_ctrl_reg[comparator_pkg::NEG_SEL_LSB +: 2] == comparator_pkg::NEG_SEL_REFERENCE)
						count_next = comparator_pkg::STARTUP_CNT_W'(REF_STARTUP_CYCLES);
					else
						count_next = comparator_pkg::STARTUP_CNT_W'(comparator_pkg::STARTUP_CYCLES);
				end
			end
			comparator_pkg::ST_STARTING: begin
				count_next = count_reg - 1'b1;
				if (count_reg <= 1)
					state_next = comparator_pkg::ST_READY;
			end
			comparator_pkg::ST_READY: ;
			default: state_next = comparator_pkg::ST_OFF;
		endcase
		if (!enable_reg) begin
			state_next = comparator_pkg::ST_OFF;
			count_next = '0;
		end
		ready_next = (state_next == comparator_pkg::ST_READY);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= comparator_pkg::ST_OFF;
			count_reg <= '0;
			ready_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			ready_reg <= ready_next;
		end
	end

	// Two stages tame the asynchronous level; the third holds the previous value
	// so each transition is seen exactly once.
	assign rise = sync2_reg & ~sync3_reg;
	assign fall = ~sync2_reg & sync3_reg;

	always_comb begin
		unique case (edge_sel)
			comparator_pkg::EDGE_BOTH:    edge_hit = rise | fall;
			comparator_pkg::EDGE_FALLING: edge_hit = fall;
			comparator_pkg::EDGE_RISING:  edge_hit = rise;
			default:                      edge_hit = 1'b0;
		endcase
	end

	// Edges during start-up are from an unsettled output and are dropped.
	assign set_flag   = edge_hit & (state_reg == comparator_pkg::ST_READY) & update_ok;
	assign clear_flag = wr_strobe & (addr == comparator_pkg::STATUS_OFFSET)
		& wdata[comparator_pkg::FLAG_BIT];

	always_comb begin
		flag_next = flag_reg;
		if (clear_flag)
			flag_next = 1'b0;
		if (set_flag)
			flag_next = 1'b1;
		irq_next = flag_next & int_en_next & update_ok;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
			flag_reg  <= 1'b0;
			irq_reg   <= 1'b0;
		end else begin
			sync1_reg <= seen;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			flag_reg  <= flag_next;
			irq_reg   <= irq_next;
		end
	end

	assign rdata                 = rdata_reg;
	assign analog_enable         = enable_reg;
	assign pos_input_select      = mux_ctrl_reg[comparator_pkg::POS_SEL_BIT];
	assign negative_input_select = mux_ctrl_reg[comparator_pkg::NEG_SEL_LSB +: 2];
	assign hysteresis_select     = ctrl_a_reg[comparator_pkg::HYST_SEL_LSB +: 2];
	assign reference_request     = ref_req_reg;
	assign pin_oe_n              = pin_oe_n_reg;
	assign compare_ready         = ready_reg;
	assign irq                   = irq_reg;

	a_set_beats_clear: assert property (@(posedge core_clk) disable iff (rst)
		set_flag && clear_flag |=> flag_reg)
		else $error("flag lost when set and clear coincide");

	a_clear_by_one: assert property (@(posedge core_clk) disable iff (rst)
		clear_flag && !set_flag |=> !flag_reg)
		else $error("writing one did not clear flag");

	a_irq_tracks_flag: assert property (@(posedge core_clk) disable iff (rst)
		(flag_reg && int_en_reg && update_ok && !clear_flag && !(wr_strobe
			&& addr == comparator_pkg::INT_CTRL_OFFSET)) |=> irq ##0 flag_reg)
		else $error("request missing while flag and enable set");

	a_irq_needs_flag: assert property (@(posedge core_clk) disable iff (rst)
		irq |-> flag_reg && int_en_reg)
		else $error("request without flag and enable");

	a_state_lag: assert property (@(posedge core_clk) disable iff (rst)
		sync3_reg == $past(seen, 3))
		else $error("state bit does not lag by three stages");

	a_powerdown_off: assert property (@(posedge core_clk) disable iff (rst)
		sleep_mode == comparator_pkg::SLEEP_POWERDOWN |=> !analog_enable && pin_oe_n && !event_out)
		else $error("comparator alive in power-down");

	a_standby_halt: assert property (@(posedge core_clk) disable iff (rst)
		sleep_mode == comparator_pkg::SLEEP_STANDBY && !ctrl_a_reg[comparator_pkg::RUN_STANDBY_BIT]
			|=> !analog_enable)
		else $error("comparator runs in standby without permission");

	a_no_status_clockless: assert property (@(posedge core_clk) disable iff (rst)
		!update_ok && !flag_reg |=> !flag_reg)
		else $error("flag set with peripheral clock stopped");

	a_rising_only: assert property (@(posedge core_clk) disable iff (rst)
		edge_sel == comparator_pkg::EDGE_RISING && fall && !rise && !flag_reg |=> !flag_reg)
		else $error("falling edge set flag in rising mode");

	a_rise_once: assert property (@(posedge core_clk) disable iff (rst)
		rise |=> !rise)
		else $error("one transition seen twice");

	a_startup_hold: assert property (@(posedge core_clk) disable iff (rst)
		$rose(analog_enable) |-> !compare_ready [*8])
		else $error("ready too early after enable");

	a_startup_end: assert property (@(posedge core_clk) disable iff (rst)
		state_reg == comparator_pkg::ST_STARTING && count_reg == 1 && enable_reg |=> compare_ready)
		else $error("start-up did not end on count");

	a_int_reg_read: assert property (@(posedge core_clk) disable iff (rst)
		rd_strobe && addr == comparator_pkg::INT_CTRL_OFFSET |=> rdata == {7'h00, $past(int_en_reg)})
		else $error("interrupt control readback wrong");

endmodule // comparator_control_logic

// File: tb/analog_front.sv
`timescale 1ns/1ns
module analog_front (
	input  wire logic       analog_enable,
	input  wire logic       pos_input_select,
	input  wire logic [1:0] negative_input_select,
	input  wire logic [1:0] hysteresis_select,
	input  wire logic [7:0] vp0,
	input  wire logic [7:0] vp1,
	input  wire logic [7:0] vn0,
	input  wire logic [7:0] vn1,
	input  wire logic [7:0] vref,
	output logic            compare_raw
);
	logic [8:0] vp;
	logic [8:0] vn;
	logic [8:0] h;
	logic       q = 1'b0;
	always_comb begin
		vp = {1'b0, pos_input_select ? vp1 : vp0};
		case (negative_input_select)
			2'h0: vn = {1'b0, vn0};
			2'h1: vn = {1'b0, vn1};
			default: vn = {1'b0, vref};
		endcase
		h = {7'h00, hysteresis_select};
	end
	// Inside the dead band the last decision holds
	always @* if (vp > vn + h) q = 1'b1; else if (vp + h <= vn) q = 1'b0;
	// Pins reach only the comparator here: no digital input buffer loads them
	// Powered down, the output is not a clean level
	assign compare_raw = analog_enable ? q : ~q;
endmodule // analog_front

// File: tb/comparator_control_logic_bench.sv
`timescale 1ns/1ns
module comparator_control_logic_bench;
	logic       core_clk = 1'b0;
	logic       rst = 1'b1;
	logic       wr_strobe = 1'b0;
	logic       rd_strobe = 1'b0;
	logic       others_need_clock = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [1:0] sleep_mode = 2'h0;
	logic [7:0] vp0 = 8'h00, vp1 = 8'h10, vn0 = 8'h80, vn1 = 8'h00, vref = 8'h40;
	logic [7:0] rdata, d, a, b, r;
	logic [1:0] negative_input_select, hysteresis_select;
	logic       analog_enable, pos_input_select, reference_request, event_out;
	logic       pin_out, pin_oe_n, compare_ready, irq, compare_raw;
	logic [1:0] codes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
	logic [7:0] offs [7] = '{8'h00, 8'h02, 8'h06, 8'h07, 8'h01, 8'h05, 8'hFF};
	int         n_fail = 0, tests_run = 0, cyc = 0, n;

	// Short reference start-up keeps the run brief but still above the plain one
	comparator_control_logic #(
		.REF_STARTUP_CYCLES(400)
	) u_comparator_control_logic (
		.core_clk              (core_clk),
		.rst                   (rst),
		.addr                  (addr),
		.wdata                 (wdata),
		.wr_strobe             (wr_strobe),
		.rd_strobe             (rd_strobe),
		.rdata                 (rdata),
		.compare_raw           (compare_raw),
		.sleep_mode            (sleep_mode),
		.others_need_clock     (others_need_clock),
		.analog_enable         (analog_enable),
		.pos_input_select      (pos_input_select),
		.negative_input_select (negative_input_select),
		.hysteresis_select     (hysteresis_select),
		.reference_request     (reference_request),
		.event_out             (event_out),
		.pin_out               (pin_out),
		.pin_oe_n              (pin_oe_n),
		.compare_ready         (compare_ready),
		.irq                   (irq)
	);
	analog_front u_analog_front (
		.analog_enable         (analog_enable),
		.pos_input_select      (pos_input_select),
		.negative_input_select (negative_input_select),
		.hysteresis_select     (hysteresis_select),
		.vp0                   (vp0),
		.vp1                   (vp1),
		.vn0                   (vn0),
		.vn1                   (vn1),
		.vref                  (vref),
		.compare_raw           (compare_raw)
	);

	always #4 core_clk = ~core_clk;

	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task wrap_up;
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task wr(input logic [7:0] ad, input logic [7:0] v);
		@(posedge core_clk);
		addr <= ad;
		wdata <= v;
		wr_strobe <= 1'b1;
		@(posedge core_clk);
		wr_strobe <= 1'b0;
	endtask

	task rd(input logic [7:0] ad);
		@(posedge core_clk);
		addr <= ad;
		rd_strobe <= 1'b1;
		@(posedge core_clk);
		rd_strobe <= 1'b0;
		#1 d = rdata;
	endtask

	task settle(input logic [7:0] p, input logic [7:0] m);
		@(posedge core_clk);
		vp1 <= p;
		vn0 <= m;
		repeat (6) @(posedge core_clk);
		#1;
	endtask

	task wait_ready;
		n = 0;
		while (compare_ready !== 1'b1 && n < 9000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask

	function automatic logic [7:0] exp_flag(input logic [1:0] code, input logic rising);
		case (code)
			2'h0: return 8'h01;
			2'h2: return {7'h00, ~rising};
			2'h3: return {7'h00, rising};
			default: return 8'h00;
		endcase
	endfunction

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			wrap_up();
		end
	end

	initial begin
		r = $urandom(32'h8E0B0E0C);
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		#1 chk("pin_oe_n", {7'h00, pin_oe_n}, 8'h01);
		foreach (offs[i]) begin
			rd(offs[i]);
			chk("reset read", d, 8'h00);
		end
		repeat (4) begin
			r = $urandom;
			wr(8'h02, r);
			rd(8'h02);
			chk("mux", d, r & 8'h8B);
			chk("pos sel", {7'h00, pos_input_select}, {7'h00, r[3]});
			chk("neg sel", {6'h00, negative_input_select}, {6'h00, r[1:0]});
			wr(8'h00, r & 8'hBE);
			rd(8'h00);
			chk("ctrl", d, r & 8'hB6);
			chk("hyst", {6'h00, hysteresis_select}, {6'h00, r[2:1]});
		end
		wr(8'h02, 8'h08);
		wr(8'h06, 8'h01);
		wr(8'h00, 8'h41);
		#1 chk("ready early", {7'h00, compare_ready}, 8'h00);
		wait_ready();
		chk("startup", {7'h00, n >= 300 && n <= 330}, 8'h01);
		chk("pin drive", {7'h00, pin_oe_n}, 8'h00);
		repeat (16) begin
			a = $urandom;
			b = $urandom;
			@(posedge core_clk);
			vp1 <= a;
			vn0 <= b;
			@(posedge core_clk);
			#1 chk("event", {7'h00, event_out}, {7'h00, a > b});
			chk("pin", {7'h00, pin_out}, {7'h00, a > b});
		end
		foreach (codes[i]) begin
			wr(8'h00, 8'h41 | {2'h0, codes[i], 4'h0});
			settle(8'h10, 8'h80);
			wr(8'h07, 8'h01);
			settle(8'h80, 8'h10);
			rd(8'h07);
			chk("status rise", d, 8'h10 | exp_flag(codes[i], 1'b1));
			chk("irq rise", {7'h00, irq}, exp_flag(codes[i], 1'b1));
			wr(8'h07, 8'h00);
			rd(8'h07);
			chk("flag kept", d, 8'h10 | exp_flag(codes[i], 1'b1));
			wr(8'h06, 8'h00);
			@(posedge core_clk);
			#1 chk("irq masked", {7'h00, irq}, 8'h00);
			wr(8'h06, 8'h01);
			wr(8'h07, 8'h01);
			settle(8'h10, 8'h80);
			rd(8'h07);
			chk("status fall", d, exp_flag(codes[i], 1'b0));
			wr(8'h07, 8'h01);
		end
		wr(8'h02, 8'h88);
		repeat (3) @(posedge core_clk);
		rd(8'h07);
		chk("inverted", {7'h00, event_out} | d, 8'h11);
		wr(8'h02, 8'h08);
		wr(8'h00, 8'h41);
		sleep_mode <= 2'h3;
		repeat (3) @(posedge core_clk);
		#1 chk("powerdown", {6'h00, analog_enable, pin_oe_n}, 8'h01);
		@(posedge core_clk);
		sleep_mode <= 2'h2;
		repeat (3) @(posedge core_clk);
		#1 chk("standby off", {7'h00, analog_enable}, 8'h00);
		@(posedge core_clk);
		sleep_mode <= 2'h0;
		wr(8'h00, 8'hC1);
		wait_ready();
		wr(8'h07, 8'h01);
		sleep_mode <= 2'h2;
		settle(8'h80, 8'h10);
		chk("standby run", {5'h00, analog_enable, event_out, pin_out}, 8'h07);
		chk("standby irq", {7'h00, irq}, 8'h00);
		@(posedge core_clk);
		others_need_clock <= 1'b1;
		settle(8'h10, 8'h80);
		rd(8'h07);
		chk("standby clocked", d, 8'h01);
		chk("standby clocked irq", {7'h00, irq}, 8'h01);
		wr(8'h07, 8'h01);
		others_need_clock <= 1'b0;
		sleep_mode <= 2'h1;
		settle(8'h80, 8'h10);
		rd(8'h07);
		chk("idle flag", d, 8'h11);
		wr(8'h07, 8'h01);
		sleep_mode <= 2'h0;
		wr(8'h00, 8'h00);
		wr(8'h02, 8'h0A);
		wr(8'h00, 8'h01);
		@(posedge core_clk);
		#1 chk("ref req", {7'h00, reference_request}, 8'h01);
		wait_ready();
		chk("ref startup", {7'h00, n >= 400 && n <= 420}, 8'h01);
		settle(8'h50, 8'h80);
		chk("ref high", {7'h00, event_out}, 8'h01);
		settle(8'h30, 8'h80);
		chk("ref low", {7'h00, event_out}, 8'h00);
		wrap_up();
	end
endmodule // comparator_control_logic_bench
